// File: cvd_consts.svh
// Shared constants of the soft-decision trellis decoder
`ifndef CVD_CONSTS_SVH
`define CVD_CONSTS_SVH
`define CVD_SOFT 3
`define CVD_NSYM 2
`define CVD_MW 8
`define CVD_HALF 9'h080
`define CVD_NSTATE 4
`define CVD_TBMAX 16
`define CVD_TBMIN 5'h08
`define CVD_TBMAX_V 5'h10
`define CVD_LMAX 5
`define CVD_ACS_LOG2 0
`define CVD_LOG2C (`CVD_LMAX - 2 - `CVD_ACS_LOG2)
`define CVD_Z ((`CVD_LOG2C == 3) ? 10 : 2 * `CVD_LOG2C)
`define CVD_DW 29
// Packed input bus positions, high to low
`define CVD_F_SYNC 28
`define CVD_F_ECLR 27
`define CVD_F_CSEL 26
`define CVD_F_TBTYPE 25
`define CVD_F_TBLEN 24:20
`define CVD_F_TBST 19:18
`define CVD_F_INST 17:16
`define CVD_F_INVAL 15:8
`define CVD_F_ERAS 7:6
`define CVD_F_SYM1 5:3
`define CVD_F_SYM0 2:0
`endif

// File: cvd_pkg.sv
// Types of the soft-decision trellis decoder
package cvd_pkg;
    typedef logic [7:0] cvd_metric_t;
    typedef enum logic [1:0] {
        PH_RUN = 2'b01,
        PH_FLUSH = 2'b10
    } cvd_phase_e;
endpackage

// File: cvd_acs_if.sv
// Carrier between the core and one add-compare-select unit
`timescale 1ns/100ps
interface cvd_acs_if;
    logic [7:0] met_a;
    logic [7:0] met_b;
    logic [3:0] bm_a;
    logic [3:0] bm_b;
    logic [8:0] sum;
    logic dec;
    modport acs (input met_a, input met_b, input bm_a, input bm_b, output sum, output dec);
    modport core (output met_a, output met_b, output bm_a, output bm_b, input sum, input dec);
endinterface

// File: cvd_acs.sv
// One add-compare-select unit, largest metric survives
`timescale 1ns/100ps
module cvd_acs (
    cvd_acs_if.acs port_if
);
    logic [8:0] sa;
    logic [8:0] sb;
    // Additive accumulation, larger sum wins
    always_comb begin
        sa = {1'b0, port_if.met_a} + {5'h00, port_if.bm_a};
        sb = {1'b0, port_if.met_b} + {5'h00, port_if.bm_b};
        port_if.dec = (sb > sa);
        port_if.sum = (sb > sa) ? sb : sa;
    end
endmodule

// File: cvd_decoder.sv
// Soft-decision trellis decoder core with streaming sink and source
`timescale 1ns/100ps
`include "cvd_consts.svh"
module cvd_decoder (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [`CVD_DW-1:0] in_data_i,
    input wire logic in_valid_i,
    input wire logic in_sop_i,
    input wire logic in_eop_i,
    output logic in_ready_o,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output logic out_bit_o,
    output logic out_sop_o,
    output logic out_eop_o,
    output logic [1:0] best_state_o,
    output logic [`CVD_MW-1:0] best_metric_o,
    output logic [7:0] norm_count_o
);
    cvd_pkg::cvd_phase_e phase_reg;
    cvd_pkg::cvd_metric_t met_reg [`CVD_NSTATE], met_use [`CVD_NSTATE], met_next [`CVD_NSTATE];
    logic [`CVD_TBMAX-1:0] path_reg [`CVD_NSTATE], path_use [`CVD_NSTATE];
    logic [`CVD_TBMAX-1:0] path_next [`CVD_NSTATE];
    logic [3:0] pace_reg;
    logic [4:0] step_reg, flush_reg, depth_reg, depth_in, depth_use, idx, step_after;
    logic ready_q_reg, oready_q_reg, csel_reg, sync_reg, tbtype_reg, first_reg;
    logic pend_reg, pend_bit_reg, pend_sop_reg, pend_eop_reg;
    logic pace_tick, accept, acc_sop, flush_step, step, norm, emit_now, csel_use;
    logic [2:0] sym0, sym1;
    logic [1:0] tbst_reg, eras, best_next, best_cur, tb_sel;

    // Branch metric: confidence toward each expected bit, erased adds nothing
    function automatic logic [3:0] bm_f(input logic e0, input logic e1,
            input logic [2:0] s0, input logic [2:0] s1, input logic [1:0] er);
        logic [2:0] v0, v1;
        logic [3:0] r;
        v0 = {~s0[2], s0[1:0]};
        v1 = {~s1[2], s1[1:0]};
        r = 4'h0;
        if (!er[0]) begin
            r = r + {1'b0, (e0 ? ~v0 : v0)};
        end
        if (!er[1]) begin
            r = r + {1'b0, (e1 ? ~v1 : v1)};
        end
        return r;
    endfunction

    // Handshake qualification and pacing
    assign pace_tick = (pace_reg == 4'(`CVD_Z - 1));
    assign accept = in_valid_i && ready_q_reg;
    assign acc_sop = accept && in_sop_i;
    assign flush_step = (phase_reg == cvd_pkg::PH_FLUSH) && pace_tick && !pend_reg;
    assign step = accept || flush_step;
    assign emit_now = pend_reg && oready_q_reg;

    // Input unpacking with optional node-sync swap
    always_comb begin
        logic sw;
        sw = acc_sop ? in_data_i[`CVD_F_SYNC] : sync_reg;
        if (flush_step) begin
            sym0 = 3'h0;
            sym1 = 3'h0;
            eras = 2'h3;
        end else if (sw) begin
            sym0 = in_data_i[`CVD_F_SYM1];
            sym1 = in_data_i[`CVD_F_SYM0];
            eras = {<<{in_data_i[`CVD_F_ERAS]}};
        end else begin
            sym0 = in_data_i[`CVD_F_SYM0];
            sym1 = in_data_i[`CVD_F_SYM1];
            eras = in_data_i[`CVD_F_ERAS];
        end
    end

    // Traceback depth clamp to the survivor length
    always_comb begin
        depth_in = in_data_i[`CVD_F_TBLEN];
        if (depth_in < `CVD_TBMIN) begin
            depth_in = `CVD_TBMIN;
        end else if (depth_in > `CVD_TBMAX_V) begin
            depth_in = `CVD_TBMAX_V;
        end
    end
    assign depth_use = acc_sop ? depth_in : depth_reg;
    assign csel_use = acc_sop ? in_data_i[`CVD_F_CSEL] : csel_reg;

    // Metric and path seeding at block start
    always_comb begin
        for (int s = 0; s < `CVD_NSTATE; s++) begin
            if (acc_sop) begin
                met_use[s] = (2'(s) == in_data_i[`CVD_F_INST]) ?
                    in_data_i[`CVD_F_INVAL] : 8'h00;
                path_use[s] = '0;
            end else begin
                met_use[s] = met_reg[s];
                path_use[s] = path_reg[s];
            end
        end
    end

    // Trellis butterflies, one unit per state
    cvd_acs_if acs_if [`CVD_NSTATE] ();
    logic [8:0] sums [`CVD_NSTATE];
    generate
        for (genvar n = 0; n < `CVD_NSTATE; n++) begin : g_acs
            localparam logic [1:0] PA = {n[0], 1'b0};
            localparam logic [1:0] PB = {n[0], 1'b1};
            localparam logic B = n[1];
            logic ga0, ga1, gb0, gb1;
            assign ga0 = B ^ PA[1] ^ PA[0];
            assign ga1 = B ^ PA[0];
            assign gb0 = B ^ PB[1] ^ PB[0];
            assign gb1 = B ^ PB[0];
            assign acs_if[n].met_a = met_use[PA];
            assign acs_if[n].met_b = met_use[PB];
            // Code select swaps the generator pair
            assign acs_if[n].bm_a = csel_use ? bm_f(ga1, ga0, sym0, sym1, eras) :
                bm_f(ga0, ga1, sym0, sym1, eras);
            assign acs_if[n].bm_b = csel_use ? bm_f(gb1, gb0, sym0, sym1, eras) :
                bm_f(gb0, gb1, sym0, sym1, eras);
            assign sums[n] = acs_if[n].sum;
            assign path_next[n] = acs_if[n].dec ?
                {path_use[PB][`CVD_TBMAX-2:0], B} : {path_use[PA][`CVD_TBMAX-2:0], B};
            cvd_acs u_acs (
                .port_if(acs_if[n])
            );
        end
    endgenerate

    // Normalization once any metric enters the upper half
    always_comb begin
        norm = 1'b0;
        for (int s = 0; s < `CVD_NSTATE; s++) begin
            if (sums[s] >= `CVD_HALF) begin
                norm = 1'b1;
            end
        end
        for (int s = 0; s < `CVD_NSTATE; s++) begin
            if (!norm) begin
                met_next[s] = sums[s][7:0];
            end else if (sums[s] >= `CVD_HALF) begin
                met_next[s] = 8'(sums[s] - `CVD_HALF);
            end else begin
                met_next[s] = 8'h00;
            end
        end
    end

    // Best state search on new and on held metrics
    always_comb begin
        best_next = 2'h0;
        best_cur = 2'h0;
        for (int s = 1; s < `CVD_NSTATE; s++) begin
            if (met_next[s] > met_next[best_next]) begin
                best_next = 2'(s);
            end
            if (met_reg[s] > met_reg[best_cur]) begin
                best_cur = 2'(s);
            end
        end
    end

    // Traceback start: given state at block end, else best
    assign tb_sel = (flush_step && tbtype_reg) ? tbst_reg : best_next;
    assign idx = depth_use - 5'h01;
    assign step_after = acc_sop ? 5'h01 : ((step_reg == 5'h1F) ? step_reg : step_reg + 5'h01);

    // Ready pulse: one clock per Z, held off by a waiting bit
    always_ff @(posedge clk_sys_i or posedge srst_i) begin
        if (srst_i) begin
            pace_reg <= 4'h0;
            in_ready_o <= 1'b0;
            ready_q_reg <= 1'b0;
            oready_q_reg <= 1'b0;
        end else begin
            pace_reg <= pace_tick ? 4'h0 : pace_reg + 4'h1;
            in_ready_o <= pace_tick && !pend_reg && (phase_reg == cvd_pkg::PH_RUN);
            ready_q_reg <= in_ready_o;
            oready_q_reg <= out_ready_i;
        end
    end

    // Block phase and flush countdown after the end-of-block transfer
    always_ff @(posedge clk_sys_i or posedge srst_i) begin
        if (srst_i) begin
            phase_reg <= cvd_pkg::PH_RUN;
            flush_reg <= 5'h00;
        end else begin
            unique case (phase_reg)
                cvd_pkg::PH_RUN: begin
                    if (accept && in_eop_i && depth_use > 5'h01) begin
                        phase_reg <= cvd_pkg::PH_FLUSH;
                        flush_reg <= depth_use - 5'h01;
                    end
                end
                cvd_pkg::PH_FLUSH: begin
                    if (flush_step) begin
                        flush_reg <= flush_reg - 5'h01;
                        if (flush_reg == 5'h01) begin
                            phase_reg <= cvd_pkg::PH_RUN;
                        end
                    end
                end
                default: begin
                    phase_reg <= cvd_pkg::PH_RUN;
                end
            endcase
        end
    end

    // Configuration latched at block start, traceback start at block end
    always_ff @(posedge clk_sys_i or posedge srst_i) begin
        if (srst_i) begin
            depth_reg <= `CVD_TBMAX_V;
            csel_reg <= 1'b0;
            sync_reg <= 1'b0;
            tbtype_reg <= 1'b0;
            tbst_reg <= 2'h0;
        end else begin
            if (acc_sop) begin
                depth_reg <= depth_in;
                csel_reg <= in_data_i[`CVD_F_CSEL];
                sync_reg <= in_data_i[`CVD_F_SYNC];
            end
            if (accept && in_eop_i) begin
                tbtype_reg <= in_data_i[`CVD_F_TBTYPE];
                tbst_reg <= in_data_i[`CVD_F_TBST];
            end
        end
    end

    // State metrics, survivors and step count
    always_ff @(posedge clk_sys_i or posedge srst_i) begin
        if (srst_i) begin
            for (int s = 0; s < `CVD_NSTATE; s++) begin
                met_reg[s] <= 8'h00;
                path_reg[s] <= '0;
            end
            step_reg <= 5'h00;
        end else if (step) begin
            for (int s = 0; s < `CVD_NSTATE; s++) begin
                met_reg[s] <= met_next[s];
                path_reg[s] <= path_next[s];
            end
            step_reg <= step_after;
        end
    end

    // Normalization counter, restarted by each block start
    always_ff @(posedge clk_sys_i or posedge srst_i) begin
        if (srst_i) begin
            norm_count_o <= 8'h00;
        end else if (step && acc_sop) begin
            norm_count_o <= {7'h00, norm};
        end else if (step && norm) begin
            norm_count_o <= norm_count_o + 8'h01;
        end
    end

    // Best metric and state for reconstructing the path total
    always_ff @(posedge clk_sys_i or posedge srst_i) begin
        if (srst_i) begin
            best_state_o <= 2'h0;
            best_metric_o <= 8'h00;
        end else begin
            best_state_o <= best_cur;
            best_metric_o <= met_reg[best_cur];
        end
    end

    // Decoded bit waits here until the sink is ready
    always_ff @(posedge clk_sys_i or posedge srst_i) begin
        if (srst_i) begin
            pend_reg <= 1'b0;
            pend_bit_reg <= 1'b0;
            pend_sop_reg <= 1'b0;
            pend_eop_reg <= 1'b0;
            first_reg <= 1'b0;
        end else begin
            if (step && step_after >= depth_use) begin
                pend_reg <= 1'b1;
                pend_bit_reg <= path_next[tb_sel][idx[3:0]];
                pend_sop_reg <= first_reg || acc_sop;
                pend_eop_reg <= flush_step && (flush_reg == 5'h01);
                first_reg <= 1'b0;
            end else begin
                if (emit_now) begin
                    pend_reg <= 1'b0;
                end
                if (acc_sop) begin
                    first_reg <= 1'b1;
                end
            end
        end
    end

    // Output source: valid one clock per bit, block flags set only together with valid
    always_ff @(posedge clk_sys_i or posedge srst_i) begin
        if (srst_i) begin
            out_valid_o <= 1'b0;
            out_bit_o <= 1'b0;
            out_sop_o <= 1'b0;
            out_eop_o <= 1'b0;
        end else begin
            out_valid_o <= emit_now;
            out_bit_o <= emit_now ? pend_bit_reg : out_bit_o;
            out_sop_o <= emit_now && pend_sop_reg;
            out_eop_o <= emit_now && pend_eop_reg;
        end
    end

    // Checks on the stream behaviour
    property p_ready_pulse;
        @(posedge clk_sys_i) disable iff (srst_i)
        in_ready_o |=> !in_ready_o [*8];
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready pulse too close");

    property p_valid_pulse;
        @(posedge clk_sys_i) disable iff (srst_i)
        out_valid_o |=> !out_valid_o;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid held over");

    property p_out_after_rdy;
        @(posedge clk_sys_i) disable iff (srst_i)
        out_valid_o |-> $past(out_ready_i, 2);
    endproperty
    a_out_after_rdy: assert property (p_out_after_rdy) else $error("valid without ready");

    property p_norm_inc;
        @(posedge clk_sys_i) disable iff (srst_i)
        (step && norm && !acc_sop) |=> norm_count_o == $past(norm_count_o) + 8'h01;
    endproperty
    a_norm_inc: assert property (p_norm_inc) else $error("norm count not bumped");

    property p_norm_clear;
        @(posedge clk_sys_i) disable iff (srst_i)
        (acc_sop && !norm) |=> norm_count_o == 8'h00;
    endproperty
    a_norm_clear: assert property (p_norm_clear) else $error("norm count not cleared");

    property p_reset_out;
        @(posedge clk_sys_i)
        srst_i |=> !in_ready_o && !out_valid_o && norm_count_o == 8'h00;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs live after reset");

    property p_best;
        @(posedge clk_sys_i) disable iff (srst_i)
        1'b1 |=> best_metric_o >= $past(met_reg[0]) && best_metric_o >= $past(met_reg[3]);
    endproperty
    a_best: assert property (p_best) else $error("best metric not largest");

    property p_metric_low;
        @(posedge clk_sys_i) disable iff (srst_i)
        step |=> met_reg[best_cur] < 8'(`CVD_HALF);
    endproperty
    a_metric_low: assert property (p_metric_low) else $error("metric left upper half");

    property p_accept;
        @(posedge clk_sys_i) disable iff (srst_i)
        (in_valid_i && !ready_q_reg && phase_reg == cvd_pkg::PH_RUN) |=> $stable(step_reg);
    endproperty
    a_accept: assert property (p_accept) else $error("data taken without ready");
endmodule

// File: cvd_partner.sv
// User-side streaming model: symbol source and decoded-bit sink
`timescale 1ns/100ps
`include "cvd_consts.svh"
module cvd_partner (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic in_ready_i,
    input wire logic stall_i,
    output logic [`CVD_DW-1:0] in_data_o,
    output logic in_valid_o,
    output logic in_sop_o,
    output logic in_eop_o,
    output logic out_ready_o,
    input wire logic out_valid_i,
    input wire logic out_bit_i,
    input wire logic out_sop_i,
    input wire logic out_eop_i
);
    logic [`CVD_DW+1:0] tx_q[$];
    logic [2:0] rx_q[$];
    logic [`CVD_DW+1:0] word;

    // Quiet bus at time zero
    initial begin
        in_data_o = '0;
        in_valid_o = 1'b0;
        in_sop_o = 1'b0;
        in_eop_o = 1'b0;
        out_ready_o = 1'b0;
    end

    // New word only on an edge that saw ready; held while ready is low
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            in_valid_o <= 1'b0;
            in_sop_o <= 1'b0;
            in_eop_o <= 1'b0;
        end else if (in_ready_i) begin
            if (tx_q.size() != 0) begin
                word = tx_q.pop_front();
                {in_sop_o, in_eop_o, in_data_o} <= word;
                in_valid_o <= 1'b1;
            end else begin
                // No data at this pulse: drop valid, wait for the next one
                in_valid_o <= 1'b0;
                in_sop_o <= 1'b0;
                in_eop_o <= 1'b0;
                in_data_o <= ~in_data_o; // Idle bus alternates between the old word and its inverse
            end
        end
    end

    // Sink: ready follows the stall request, every valid bit is kept
    always @(posedge clk_sys_i) begin
        out_ready_o <= ~stall_i; // Stays high as if tied, outside stalls
        if (out_valid_i) begin
            rx_q.push_back({out_sop_i, out_eop_i, out_bit_i});
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench for the trellis decoder
`timescale 1ns/100ps
`include "cvd_consts.svh"
module testbench;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic stall = 1'b0;
    logic [`CVD_DW-1:0] in_data;
    logic in_valid, in_sop, in_eop, in_ready, out_ready;
    logic out_valid, out_bit, out_sop, out_eop;
    logic [1:0] best_state;
    logic [7:0] best_metric, norm_count;
    logic rdy_q = 1'b0;
    logic ov_q = 1'b0;
    logic [1:0] ordy_q = 2'b00;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0, gap = 100, stall_len = 0, sop_t = -10, lat = 0;
    int norm_max = 0, tot0 = 0, tot1 = 0;

    cvd_decoder u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .in_data_i(in_data),
        .in_valid_i(in_valid), .in_sop_i(in_sop), .in_eop_i(in_eop), .in_ready_o(in_ready),
        .out_ready_i(out_ready), .out_valid_o(out_valid), .out_bit_o(out_bit),
        .out_sop_o(out_sop), .out_eop_o(out_eop), .best_state_o(best_state),
        .best_metric_o(best_metric), .norm_count_o(norm_count));

    cvd_partner u_user (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .in_ready_i(in_ready),
        .stall_i(stall), .in_data_o(in_data), .in_valid_o(in_valid), .in_sop_o(in_sop),
        .in_eop_o(in_eop), .out_ready_o(out_ready), .out_valid_i(out_valid),
        .out_bit_i(out_bit), .out_sop_i(out_sop), .out_eop_i(out_eop));

    // 20 MHz system clock
    initial forever #25 clk_sys_i = ~clk_sys_i;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Bounded wait for a number of collected bits
    task automatic wait_rx(input int cnt);
        int n;
        for (n = 0; n < 3000 && u_user.rx_q.size() < cnt; n++) @(posedge clk_sys_i);
        if (n >= 3000) begin
            error_cnt++;
            final_report();
        end
    endtask

    // Stream watcher: pacing, output handshake, metric bookkeeping
    always @(posedge clk_sys_i) begin
        cyc++;
        if (!srst_i) begin
            if (in_ready) begin
                check(gap >= `CVD_Z, 1'b1);
                check(stall_len > 25, 1'b0);
            end
            if (out_valid) begin
                check(ov_q, 1'b0);
                check(ordy_q[1], 1'b1);
            end
            if (in_valid && rdy_q && in_sop) begin
                sop_t = cyc;
                norm_max = 0;
            end
            if (cyc == sop_t + 3) check(norm_count, 8'h00);
            if (out_valid && out_sop) begin
                lat = cyc - sop_t;
                tot0 = norm_count * 128 + best_metric;
            end
            if (out_valid && out_eop) tot1 = norm_count * 128 + best_metric;
            // Skip the count left over from the previous block
            if (cyc > sop_t + 1 && norm_count > norm_max) norm_max = norm_count;
        end
        gap = in_ready ? 1 : gap + 1;
        stall_len = out_ready ? 0 : stall_len + 1;
        rdy_q = in_ready;
        ov_q = out_valid;
        ordy_q = {ordy_q[0], out_ready};
    end

    // Encode 32 bits with the 7/5 code, depuncture, feed and compare
    task automatic run_block(input int idx, input logic csel, input logic sync,
        input logic [4:0] depth, input int per, input logic [7:0] r0, input logic [7:0] r1);
        logic [1:0] st;
        logic b, c0, c1, e0, e1, t;
        logic [2:0] s0, s1, sx;
        logic [31:0] bits;
        logic [31:0] exp_bits;
        logic [`CVD_DW-1:0] w;
        logic [2:0] r;
        int k;
        st = 2'b00;
        bits = 32'hB5C3_96A1 ^ (idx * 32'h1357_9BDF);
        norm_max = 0;
        for (k = 0; k < 32; k++) begin
            b = (k < 30) ? bits[k] : 1'b0; // Zero tail ends in state 0
            exp_bits[k] = b;
            c0 = b ^ st[1] ^ st[0];
            c1 = b ^ st[0];
            st = {b, st[1]};
            if (csel) begin
                t = c0;
                c0 = c1;
                c1 = t;
            end
            e0 = !r0[per - 1 - (k % per)];
            e1 = !r1[per - 1 - (k % per)];
            s0 = c0 ? 3'h4 : 3'h3;
            s1 = c1 ? 3'h4 : 3'h3;
            if (e0) s0 = s0 ^ 3'h7; // Erased place carries a wrong symbol
            if (e1) s1 = s1 ^ 3'h7;
            if (sync) begin
                sx = s0;
                s0 = s1;
                s1 = sx;
                t = e0;
                e0 = e1;
                e1 = t;
            end
            w = '0;
            w[`CVD_F_SYNC] = sync;
            w[`CVD_F_CSEL] = csel;
            w[`CVD_F_TBTYPE] = 1'b1;
            w[`CVD_F_TBLEN] = depth;
            w[`CVD_F_INVAL] = 8'h40;
            w[`CVD_F_ERAS] = {e1, e0};
            w[`CVD_F_SYM1] = s1;
            w[`CVD_F_SYM0] = s0;
            u_user.tx_q.push_back({k == 0, k == 31, w});
            if (idx == 2 && k == 3) repeat (60) @(posedge clk_sys_i);
        end
        if (idx == 3) begin
            wait_rx(3);
            stall <= 1'b1;
            repeat (50) @(posedge clk_sys_i);
            stall <= 1'b0;
        end
        wait_rx(32);
        repeat (30) @(posedge clk_sys_i);
        check(u_user.rx_q.size(), 16'h0020);
        check(best_state, 2'h0);
        for (k = 0; k < 32; k++) begin
            r = u_user.rx_q.pop_front();
            check(r, {k == 0, k == 31, exp_bits[k]});
        end
        check(norm_max >= 1, 1'b1);
        check(tot1 > tot0, 1'b1);
        if (idx == 0) check(lat >= `CVD_Z * 6 && lat <= `CVD_Z * 12, 1'b1);
    endtask

    logic cs[7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic sy[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    int pr[7] = '{1, 1, 1, 1, 2, 3, 5};
    logic [7:0] ra[7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h05, 8'h1E};
    logic [7:0] rb[7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h06, 8'h12};

    // Main sequence
    initial begin
        int i;
        repeat (20) @(posedge clk_sys_i);
        check({in_ready, out_valid, norm_count}, 16'h0000);
        srst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1 check({in_ready, out_valid, norm_count}, 16'h0000);
        for (i = 0; i < 7; i++) begin
            run_block(i, cs[i], sy[i], (i < 4 && i != 1) ? `CVD_TBMIN : `CVD_TBMAX_V,
                pr[i], ra[i], rb[i]);
            if (i == 3) begin
                // Reset again between blocks
                srst_i <= 1'b1;
                repeat (3) @(posedge clk_sys_i);
                srst_i <= 1'b0; // Released on a rising edge
                #1 check({in_ready, out_valid, norm_count}, 16'h0000);
            end
        end
        final_report();
    end
endmodule
